// file: design/io_ctrl_pkg.sv
// Overview of operation
// - clock pin enable bit; frequency picks 25/125 MHz
// - inband enable cleared by reset, loaded from strap on first edge after release
// - match enable drops frames with foreign MAC
// - management reset bit self-clears after one pulse
// - two-bit response queue field, resets to one
// - three-bit port field, codes pick ports 1-7
// - sixteen-bit frame type field, reset 0x40FE
// - high-speed pad drive code, resets to 110
// - low-speed pad drive code, resets to 010
package io_ctrl_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [15:0] OFS_CLK_OUT  = 16'h0103;
    localparam logic [15:0] OFS_MGMT_B3  = 16'h0104; // bits 31:24
    localparam logic [15:0] OFS_MGMT_B2  = 16'h0105; // bits 23:16
    localparam logic [15:0] OFS_MGMT_B1  = 16'h0106; // bits 15:8
    localparam logic [15:0] OFS_MGMT_B0  = 16'h0107; // bits 7:0
    localparam logic [15:0] OFS_DRIVE    = 16'h010D;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CLK_EN_BIT    = 1;
    localparam int CLK_FREQ_BIT  = 0;
    localparam int MGMT_EN_BIT   = 31;
    localparam int MATCH_EN_BIT  = 30;
    localparam int MGMT_RST_BIT  = 29;
    localparam int QUEUE_LSB     = 22;
    localparam int PORT_LSB      = 16;
    localparam int HS_DRV_LSB    = 4;
    localparam int LS_DRV_LSB    = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  CLK_OUT_RST  = 8'h02;  // enable set, 25 MHz
    localparam logic [1:0]  QUEUE_RST    = 2'h1;
    localparam logic [2:0]  PORT_RST     = 3'h6;   // port 7
    localparam logic [15:0] TPID_RST     = 16'h40FE;
    localparam logic [2:0]  HS_DRV_RST   = 3'h6;
    localparam logic [2:0]  LS_DRV_RST   = 3'h2;
    localparam logic [7:0]  DRIVE_RST    = 8'h62;

    // writable masks: reserved RO bits stay zero
    localparam logic [7:0]  CLK_OUT_WMASK = 8'h1F;
    localparam logic [31:0] MGMT_WMASK    = 32'hE0C7FFFF;

endpackage : io_ctrl_pkg

// file: design/mgmt_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// configuration and result signals between register bank and frame filter
interface mgmt_cfg_if;
    logic        enable;
    logic        match_en;
    logic        sm_reset;
    logic [15:0] tpid;
    logic        accept;
    logic        drop;

    modport regs   (output enable, output match_en, output sm_reset, output tpid,
                    input accept, input drop);
    modport filter (input enable, input match_en, input sm_reset, input tpid,
                    output accept, output drop);
endinterface : mgmt_cfg_if
`default_nettype wire

// file: design/mgmt_frame_filter.sv
`timescale 1ns/1ps
`default_nettype none
// classifies received frame headers as management frames
module mgmt_frame_filter
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_hdr_valid,
    input  wire logic [47:0] i_hdr_dest_mac,
    input  wire logic [15:0] i_hdr_type,
    input  wire logic [47:0] i_switch_mac,
    mgmt_cfg_if.filter       cfg
);
    logic is_mgmt;
    logic mac_ok;

    // ----------------------------------------------------------------
    // classification
    // ----------------------------------------------------------------
    assign is_mgmt = cfg.enable && (i_hdr_type == cfg.tpid);
    assign mac_ok  = !cfg.match_en || (i_hdr_dest_mac == i_switch_mac);

    // one-cycle verdict pulses, quiet while state machine resets
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cfg.accept <= 1'b0;
            cfg.drop   <= 1'b0;
        end
        else
        begin
            cfg.accept <= i_hdr_valid && !cfg.sm_reset && is_mgmt && mac_ok;
            cfg.drop   <= i_hdr_valid && !cfg.sm_reset && is_mgmt && !mac_ok;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_mac_mismatch_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_hdr_valid && !cfg.sm_reset && cfg.enable && cfg.match_en
         && i_hdr_type == cfg.tpid && i_hdr_dest_mac != i_switch_mac)
        |=> (cfg.drop && !cfg.accept))
        else $error("foreign MAC frame not dropped");

    a_no_match_check: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_hdr_valid && !cfg.sm_reset && cfg.enable && !cfg.match_en
         && i_hdr_type == cfg.tpid) |=> cfg.accept)
        else $error("frame rejected with match check off");

    a_type_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_hdr_type != cfg.tpid) |=> !(cfg.accept || cfg.drop))
        else $error("frame with other type classified");

endmodule : mgmt_frame_filter
`default_nettype wire

// file: design/global_io_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
// global I/O control register bank with management frame classification
module global_io_control_regs
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    // byte register port
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_reg_rvalid,
    // strap and frame header
    input  wire logic        i_inband_management_strap,
    input  wire logic        i_hdr_valid,
    input  wire logic [47:0] i_hdr_dest_mac,
    input  wire logic [15:0] i_hdr_type,
    input  wire logic [47:0] i_switch_mac,
    // controls
    output logic             o_ref_clock_output_pin_en,
    output logic             o_ref_clock_output_sel_125,
    output logic             o_inband_management_en,
    output logic             o_inband_management_reset,
    output logic      [1:0]  o_resp_queue,
    output logic      [2:0]  o_mgmt_port,
    output logic      [15:0] o_mgmt_tpid,
    output logic      [2:0]  o_hs_drive,
    output logic      [2:0]  o_ls_drive,
    output logic             o_mgmt_accept,
    output logic             o_mgmt_drop
);

    logic [7:0]  clk_out_q;
    logic [31:0] mgmt_q;
    logic [7:0]  drive_q;
    logic        strap_done_q;
    logic [7:0]  rdata_d;

    mgmt_cfg_if cfg_if ();

    // pick one byte of the 32-bit control word, 0x104 holds the top byte
    function automatic logic [7:0] lane_get(input logic [31:0] w, input logic [1:0] lane);
        lane_get = w[8*(3-lane) +: 8];
    endfunction : lane_get

    // ----------------------------------------------------------------
    // output clock control
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            clk_out_q <= io_ctrl_pkg::CLK_OUT_RST;
        else if (i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_CLK_OUT)
            clk_out_q <= i_reg_wdata & io_ctrl_pkg::CLK_OUT_WMASK;
    end

    // pin enable and frequency select
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_ref_clock_output_pin_en  <= io_ctrl_pkg::CLK_OUT_RST[io_ctrl_pkg::CLK_EN_BIT];
            o_ref_clock_output_sel_125 <= io_ctrl_pkg::CLK_OUT_RST[io_ctrl_pkg::CLK_FREQ_BIT];
        end
        else
        begin
            o_ref_clock_output_pin_en  <= clk_out_q[io_ctrl_pkg::CLK_EN_BIT];
            o_ref_clock_output_sel_125 <= clk_out_q[io_ctrl_pkg::CLK_FREQ_BIT];
        end
    end

    // ----------------------------------------------------------------
    // management control word
    // ----------------------------------------------------------------
    // strap caught on first edge after release; self-clearing reset bit
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mgmt_q       <= {3'h0, 5'h00, io_ctrl_pkg::QUEUE_RST, 3'h0,
                             io_ctrl_pkg::PORT_RST, io_ctrl_pkg::TPID_RST};
            strap_done_q <= 1'b0;
        end
        else
        begin
            strap_done_q <= 1'b1;
            if (!strap_done_q)
                mgmt_q[io_ctrl_pkg::MGMT_EN_BIT] <= i_inband_management_strap;
            else
            begin
                mgmt_q[io_ctrl_pkg::MGMT_RST_BIT] <= 1'b0;
                if (i_reg_wr && i_reg_addr[15:2] == io_ctrl_pkg::OFS_MGMT_B3[15:2])
                    mgmt_q[8*(3-i_reg_addr[1:0]) +: 8] <= i_reg_wdata
                        & lane_get(io_ctrl_pkg::MGMT_WMASK, i_reg_addr[1:0]);
            end
        end
    end

    // control word fields onto pins
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_inband_management_en    <= 1'b0;
            o_inband_management_reset <= 1'b0;
            o_resp_queue              <= io_ctrl_pkg::QUEUE_RST;
            o_mgmt_port               <= io_ctrl_pkg::PORT_RST;
            o_mgmt_tpid               <= io_ctrl_pkg::TPID_RST;
        end
        else
        begin
            o_inband_management_en    <= mgmt_q[io_ctrl_pkg::MGMT_EN_BIT];
            o_inband_management_reset <= mgmt_q[io_ctrl_pkg::MGMT_RST_BIT];
            o_resp_queue              <= mgmt_q[io_ctrl_pkg::QUEUE_LSB +: 2];
            o_mgmt_port               <= mgmt_q[io_ctrl_pkg::PORT_LSB +: 3];
            o_mgmt_tpid               <= mgmt_q[15:0];
        end
    end

    // ----------------------------------------------------------------
    // pad drive strength
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            drive_q <= io_ctrl_pkg::DRIVE_RST;
        else if (i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_DRIVE)
            drive_q <= i_reg_wdata;
    end

    // drive codes onto pins
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_hs_drive <= io_ctrl_pkg::HS_DRV_RST;
            o_ls_drive <= io_ctrl_pkg::LS_DRV_RST;
        end
        else
        begin
            o_hs_drive <= drive_q[io_ctrl_pkg::HS_DRV_LSB +: 3];
            o_ls_drive <= drive_q[io_ctrl_pkg::LS_DRV_LSB +: 3];
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unmapped addresses read zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (i_reg_addr == io_ctrl_pkg::OFS_CLK_OUT)
            rdata_d = clk_out_q;
        else if (i_reg_addr[15:2] == io_ctrl_pkg::OFS_MGMT_B3[15:2])
            rdata_d = lane_get(mgmt_q, i_reg_addr[1:0]);
        else if (i_reg_addr == io_ctrl_pkg::OFS_DRIVE)
            rdata_d = drive_q;
    end

    // read data one cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
                o_reg_rdata <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // frame classification
    // ----------------------------------------------------------------
    assign cfg_if.enable   = o_inband_management_en;
    assign cfg_if.match_en = mgmt_q[io_ctrl_pkg::MATCH_EN_BIT];
    assign cfg_if.sm_reset = o_inband_management_reset;
    assign cfg_if.tpid     = o_mgmt_tpid;

    mgmt_frame_filter u_filter
    (
        .i_ref_clk      (i_ref_clk),
        .i_rstn         (i_rstn),
        .i_hdr_valid    (i_hdr_valid),
        .i_hdr_dest_mac (i_hdr_dest_mac),
        .i_hdr_type     (i_hdr_type),
        .i_switch_mac   (i_switch_mac),
        .cfg            (cfg_if.filter)
    );

    assign o_mgmt_accept = cfg_if.accept;
    assign o_mgmt_drop   = cfg_if.drop;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_clk_pin_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_CLK_OUT && strap_done_q)
        |=> ##1 (o_ref_clock_output_pin_en == $past(i_reg_wdata[1], 2)
                 && o_ref_clock_output_sel_125 == $past(i_reg_wdata[0], 2)))
        else $error("clock pin controls do not follow write");

    a_strap_load: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(strap_done_q) |=> (o_inband_management_en == $past(i_inband_management_strap, 2)))
        else $error("enable not loaded from strap");

    a_reset_self_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_inband_management_reset) |=> !o_inband_management_reset)
        else $error("management reset not self-clearing");

    a_reset_on_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (strap_done_q && i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_MGMT_B3
         && i_reg_wdata[5]) |=> ##1 o_inband_management_reset)
        else $error("management reset not pulsed");

    a_queue_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (strap_done_q && i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_MGMT_B2)
        |=> ##1 (o_resp_queue == $past(i_reg_wdata[7:6], 2)
                 && o_mgmt_port == $past(i_reg_wdata[2:0], 2)))
        else $error("queue or port field not written");

    a_tpid_stable: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !(i_reg_wr && i_reg_addr[15:1] == io_ctrl_pkg::OFS_MGMT_B1[15:1])
        |=> ##1 $stable(o_mgmt_tpid))
        else $error("frame type changed without write");

    a_drive_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_DRIVE)
        |=> ##1 (o_hs_drive == $past(i_reg_wdata[6:4], 2)
                 && o_ls_drive == $past(i_reg_wdata[2:0], 2)))
        else $error("drive codes not written");

    a_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_reg_rd && i_reg_addr == io_ctrl_pkg::OFS_MGMT_B3) |=> o_reg_rdata[4:0] == 5'h00)
        else $error("reserved read-only bits not zero");

    // reserved read-only bits of the clock and queue/port bytes read zero
    a_clk_reserved_ro: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_reg_rd && i_reg_addr == io_ctrl_pkg::OFS_CLK_OUT) |=> (o_reg_rdata[7:5] == 3'h0))
        else $error("clock byte reserved bits not zero");

    a_b2_reserved_ro: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (i_reg_rd && i_reg_addr == io_ctrl_pkg::OFS_MGMT_B2) |=> (o_reg_rdata[5:3] == 3'h0))
        else $error("queue byte reserved bits not zero");

    // ----------------------------------------------------------------
    // read handshake and field hold checks
    // ----------------------------------------------------------------
    // every read strobe answers with exactly one valid pulse
    a_rvalid_answer: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe without valid pulse");

    a_rvalid_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !i_reg_rd |=> !o_reg_rvalid)
        else $error("valid pulse without read strobe");

    // self-clearing bit survives only one cycle unless rewritten
    a_rst_bit_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (mgmt_q[io_ctrl_pkg::MGMT_RST_BIT]
         && !(i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_MGMT_B3))
        |=> !mgmt_q[io_ctrl_pkg::MGMT_RST_BIT])
        else $error("management reset bit stuck");

    // clock, queue, port and drive outputs move only two cycles after a write to their byte
    a_clk_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !(i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_CLK_OUT)
        |=> ##1 ($stable(o_ref_clock_output_pin_en) && $stable(o_ref_clock_output_sel_125)))
        else $error("clock pin controls changed without write");

    a_queue_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !(strap_done_q && i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_MGMT_B2)
        |=> ##1 $stable(o_resp_queue))
        else $error("response queue changed without write");

    a_port_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !(strap_done_q && i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_MGMT_B2)
        |=> ##1 $stable(o_mgmt_port))
        else $error("management port changed without write");

    a_drive_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !(i_reg_wr && i_reg_addr == io_ctrl_pkg::OFS_DRIVE)
        |=> ##1 ($stable(o_hs_drive) && $stable(o_ls_drive)))
        else $error("drive codes changed without write");

    // ----------------------------------------------------------------
    // classification gate checks
    // ----------------------------------------------------------------
    // a verdict is one of two, never both
    a_verdict_excl: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !(o_mgmt_accept && o_mgmt_drop))
        else $error("frame both accepted and dropped");

    // no verdict while disabled or while the state machine resets
    a_disabled_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !o_inband_management_en |=> !(o_mgmt_accept || o_mgmt_drop))
        else $error("frame classified while disabled");

    a_reset_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_inband_management_reset |=> !(o_mgmt_accept || o_mgmt_drop))
        else $error("frame classified during state machine reset");

endmodule : global_io_control_regs
`default_nettype wire

// file: dv/mgmt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host side of the byte register port
// ----------------------------------------------------------------
module mgmt_host_model
(
    input  wire logic        i_ref_clk,
    input  wire logic [7:0]  i_reg_rdata,
    input  wire logic        i_reg_rvalid,
    output logic      [15:0] o_reg_addr,
    output logic             o_reg_wr,
    output logic      [7:0]  o_reg_wdata,
    output logic             o_reg_rd
);
    // idle bus at time zero
    initial
    begin
        o_reg_addr  = 16'hFFFF;
        o_reg_wr    = 1'b0;
        o_reg_wdata = 8'hFF;
        o_reg_rd    = 1'b0;
    end

    // one write strobe; released lines show the inverse so stale data never passes
    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        o_reg_wr    <= 1'b1;
        @(posedge i_ref_clk);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
    endtask : wr_byte

    // one read strobe, then a bounded wait for the valid pulse
    task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        o_reg_addr <= a;
        o_reg_rd   <= 1'b1;
        @(posedge i_ref_clk);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~a;
        #1;
        while (i_reg_rvalid !== 1'b1 && n < 4)
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hXX;
    endtask : rd_byte
endmodule : mgmt_host_model
`default_nettype wire

// file: dv/global_io_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module global_io_control_regs_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        strap = 1'b1;
    logic        hv = 1'b0;
    logic [47:0] dmac = 48'h0;
    logic [15:0] htype = 16'h0;
    logic [47:0] smac = 48'h0A0B0C0D0E0F;
    logic [15:0] addr;
    logic        wr, rd, rvalid, pin_en, sel, en, mrst, acc, drp;
    logic [7:0]  wdata, rdata;
    logic [1:0]  queue;
    logic [2:0]  port, hs, ls;
    logic [15:0] tpid;
    int          miscompares = 0;
    int          n_compared = 0;

    // ----------------------------------------------------------------
    // clock, host and device
    // ----------------------------------------------------------------
    always #5 clk = ~clk;

    mgmt_host_model host (.i_ref_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
        .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata), .o_reg_rd(rd));

    global_io_control_regs dut (.i_ref_clk(clk), .i_rstn(rstn), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_inband_management_strap(strap), .i_hdr_valid(hv),
        .i_hdr_dest_mac(dmac), .i_hdr_type(htype), .i_switch_mac(smac),
        .o_ref_clock_output_pin_en(pin_en), .o_ref_clock_output_sel_125(sel),
        .o_inband_management_en(en), .o_inband_management_reset(mrst),
        .o_resp_queue(queue), .o_mgmt_port(port), .o_mgmt_tpid(tpid),
        .o_hs_drive(hs), .o_ls_drive(ls), .o_mgmt_accept(acc), .o_mgmt_drop(drp));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic do_reset(input logic s);
        @(posedge clk);
        strap <= s;
        rstn  <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    // write one byte, let the field outputs settle
    task automatic wr_chk(input logic [15:0] a, input logic [7:0] d);
        host.wr_byte(a, d);
        repeat (2) @(posedge clk);
        #1;
    endtask : wr_chk

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd_byte(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rd_chk

    // one header; count accept and drop pulses that follow it
    task automatic hdr(input logic [47:0] m, input logic [15:0] t, input int ea, input int ed);
        int na, nd;
        na = 0;
        nd = 0;
        @(posedge clk);
        hv    <= 1'b1;
        dmac  <= m;
        htype <= t;
        @(posedge clk);
        hv    <= 1'b0;
        dmac  <= ~m;
        htype <= ~t;
        repeat (3)
        begin
            #1;
            na += (acc === 1'b1);
            nd += (drp === 1'b1);
            @(posedge clk);
        end
        chk("accept count", ea, na);
        chk("drop count", ed, nd);
    endtask : hdr

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values;
        logic [15:0] ad [7] = '{16'h0103, 16'h0104, 16'h0105, 16'h0106, 16'h0107,
                                16'h010D, 16'h0101};
        logic [7:0]  ex [7] = '{8'h02, 8'h80, 8'h46, 8'h40, 8'hFE, 8'h62, 8'h00};
        #1;
        chk("pin_en", 1, pin_en);
        chk("sel_125", 0, sel);
        chk("mgmt_en", 1, en);
        chk("queue", io_ctrl_pkg::QUEUE_RST, queue);
        chk("port", io_ctrl_pkg::PORT_RST, port);
        chk("tpid", io_ctrl_pkg::TPID_RST, tpid);
        chk("hs", io_ctrl_pkg::HS_DRV_RST, hs);
        chk("ls", io_ctrl_pkg::LS_DRV_RST, ls);
        for (int i = 0; i < 7; i++)
            rd_chk(ad[i], ex[i]);
    endtask : t_reset_values

    task automatic t_filter;
        hdr(48'h112233445566, 16'h40FE, 1, 0);
        hdr(smac, 16'h1234, 0, 0);
        wr_chk(16'h0104, 8'hC0);
        hdr(48'h112233445566, 16'h40FE, 0, 1);
        hdr(smac, 16'h40FE, 1, 0);
    endtask : t_filter

    task automatic t_clock_ctrl;
        wr_chk(16'h0103, 8'hFF);
        chk("sel_125", 1, sel);
        rd_chk(16'h0103, 8'h1F);
        wr_chk(16'h0103, 8'h00);
        chk("pin_en", 0, pin_en);
        rd_chk(16'h0103, 8'h00);
    endtask : t_clock_ctrl

    task automatic t_control_word;
        int np;
        np = 0;
        host.wr_byte(16'h0104, 8'hFF);
        repeat (5)
        begin
            #1;
            np += (mrst === 1'b1);
            @(posedge clk);
        end
        chk("sm reset pulses", 1, np);
        rd_chk(16'h0104, 8'hC0);
        wr_chk(16'h0104, 8'h00);
        chk("mgmt_en", 0, en);
        hdr(smac, 16'h40FE, 0, 0);
        wr_chk(16'h0105, 8'hFF);
        chk("queue", 3, queue);
        chk("port", 7, port);
        rd_chk(16'h0105, 8'hC7);
        wr_chk(16'h0106, 8'h12);
        wr_chk(16'h0107, 8'h34);
        chk("tpid", 16'h1234, tpid);
    endtask : t_control_word

    task automatic t_drive;
        wr_chk(16'h010D, 8'h35);
        chk("hs", 3, hs);
        chk("ls", 5, ls);
        wr_chk(16'h010D, 8'h88);
        rd_chk(16'h010D, 8'h88);
        wr_chk(16'h0101, 8'hFF);
        rd_chk(16'h0101, 8'h00);
    endtask : t_drive

    task automatic t_strap_low;
        do_reset(1'b0);
        #1;
        chk("mgmt_en", 0, en);
        rd_chk(16'h0104, 8'h00);
        rd_chk(16'h010D, io_ctrl_pkg::DRIVE_RST);
    endtask : t_strap_low

    task automatic end_sim;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // main sequence
    initial
    begin
        do_reset(1'b1);
        t_reset_values();
        t_filter();
        t_clock_ctrl();
        t_control_word();
        t_drive();
        t_strap_low();
        end_sim();
    end

    // watchdog cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule : global_io_control_regs_tb
`default_nettype wire
